// ==== pkg/pbr_cfg.svh ====
`ifndef PBR_CFG_SVH
`define PBR_CFG_SVH
// bus size encodings
`define PBR_SZ_LONG    2'b00
`define PBR_SZ_BYTE    2'b01
`define PBR_SZ_WORD    2'b10
`define PBR_SZ_LINE    2'b11
// sequencer states, gray along idle-start-wait-burst
`define PBR_ST_IDLE    2'b00
`define PBR_ST_START   2'b01
`define PBR_ST_WAIT    2'b11
`define PBR_ST_BURST   2'b10
// index of the last long word of a line
`define PBR_LINE_LAST  2'd3
// free fifo slots needed before a cycle starts
`define PBR_FIFO_SLACK 4
`define PBR_FIFO_DEPTH 16
`define PBR_DATA_W     32
`endif

// ==== pkg/pbr_pkg.sv ====
package pbr_pkg;
`include "pbr_cfg.svh"

  typedef enum logic [1:0]
  {
    PBR_LONG = `PBR_SZ_LONG,
    PBR_BYTE = `PBR_SZ_BYTE,
    PBR_WORD = `PBR_SZ_WORD,
    PBR_LINE = `PBR_SZ_LINE
  } pbr_size_t;

  typedef enum logic [1:0]
  {
    ST_IDLE  = `PBR_ST_IDLE,
    ST_START = `PBR_ST_START,
    ST_WAIT  = `PBR_ST_WAIT,
    ST_BURST = `PBR_ST_BURST
  } pbr_state_t;

  typedef struct packed {
    logic [31:0] addr;
    pbr_size_t   op_size;
    logic [1:0]  acc_type;
    logic [2:0]  acc_mod;
    logic [1:0]  upa;
    logic        noncache;
    logic        alt_space;
    logic        block_move;
  } pbr_req_t;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  lane;
    pbr_size_t   size;
    logic        cache_inhibit;
    logic        last;
  } pbr_beat_t;
endpackage

// ==== src/pbr_read_ctrl.sv ====
`timescale 1ns/1ps

module pbr_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  // clock
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  output logic [AW:0]       level
);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic          wr;
  logic          rd;
  logic [AW:0]   next_level;

  assign wr = in_valid && in_ready;
  assign rd = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_comb
  begin
    next_level = level;
    if (wr && !rd)
      next_level = level + 1'b1;
    else if (rd && !wr)
      next_level = level - 1'b1;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      level     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end
    else if (ce)
    begin
      if (wr)
        wr_ptr <= AW'(wr_ptr + 1'b1);
      if (rd)
        rd_ptr <= AW'(rd_ptr + 1'b1);
      level     <= next_level;
      in_ready  <= next_level != (AW+1)'(DEPTH);
      out_valid <= next_level != '0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (ce && wr)
      mem[wr_ptr] <= in_data;
  end
endmodule

module pbr_read_ctrl #(
  parameter int DEPTH = `PBR_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              ce,
  // read requests from the memory unit
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire pbr_pkg::pbr_req_t req,
  // returned data
  output logic                   rd_valid,
  input  wire logic              rd_ready,
  output pbr_pkg::pbr_beat_t     rd_beat,
  output logic                   line_locked,
  // bus outputs
  output logic [31:0]            bus_addr,
  output logic                   read_write_n,
  output pbr_pkg::pbr_size_t     xfer_size,
  output logic [1:0]             access_type,
  output logic [2:0]             access_modifier,
  output logic [1:0]             user_attr_bits,
  output logic                   cache_inhibit_out,
  output logic                   transfer_start_n,
  output logic                   transfer_in_progress_n,
  // bus inputs
  input  wire logic [31:0]       data_in,
  input  wire logic              xfer_acknowledge_n,
  input  wire logic              burst_inhibit_in_n,
  input  wire logic              cache_inhibit_in_n
);
  import pbr_pkg::*;

  localparam int AW = $clog2(DEPTH);

  pbr_state_t  st;
  pbr_req_t    hold;
  pbr_req_t    cur;
  logic        hold_v;
  logic        next_hold_v;
  logic [2:0]  rem;
  logic [1:0]  bcnt;
  logic        line_ci;
  logic        fifo_ready;
  logic [AW:0] fifo_level;
  logic        sampling;
  logic        is_line;
  logic        more;
  logic        first_line;
  logic        tbi_hit;
  logic        free_slot;
  logic        room;
  logic        take;
  logic [31:0] nxt_addr;
  pbr_beat_t   beat;

  // bytes moved by one bus cycle of a given size
  function automatic logic [2:0] size_bytes(input pbr_size_t s);
    case (s)
      PBR_BYTE: size_bytes = 3'h1;
      PBR_WORD: size_bytes = 3'h2;
      default:  size_bytes = 3'h4;
    endcase
  endfunction

  // largest aligned piece at this offset for the bytes left
  function automatic pbr_size_t piece_size(input logic [1:0] a, input logic [2:0] n);
    if (a[0] || n == 3'h1)
      piece_size = PBR_BYTE;
    else if (!a[1] && n >= 3'h4)
      piece_size = PBR_LONG;
    else
      piece_size = PBR_WORD;
  endfunction

  // a full fifo withholds acknowledge recognition, so the cycle waits
  assign sampling   = (st == ST_WAIT || st == ST_BURST) && !xfer_acknowledge_n && fifo_ready;
  assign is_line    = cur.op_size == PBR_LINE;
  assign more       = is_line ? (bcnt != `PBR_LINE_LAST) : (rem != 3'h0);
  assign first_line = st == ST_WAIT && is_line && bcnt == 2'd0;
  assign tbi_hit    = first_line && !burst_inhibit_in_n;
  assign free_slot  = st == ST_IDLE || (sampling && !more);
  assign room       = fifo_level <= (AW+1)'(DEPTH - `PBR_FIFO_SLACK);
  assign take       = free_slot && hold_v && room;
  assign nxt_addr   = bus_addr + {29'h0, size_bytes(xfer_size)};

  // request holding register
  assign next_hold_v = (hold_v && !take) || (req_valid && req_ready);

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hold_v    <= 1'b0;
      req_ready <= 1'b0;
      hold      <= '0;
    end
    else if (ce)
    begin
      hold_v    <= next_hold_v;
      req_ready <= !next_hold_v;
      if (req_valid && req_ready)
        hold <= req;
    end
  end

  // cycle sequencer and handshake outputs
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st                     <= ST_IDLE;
      transfer_start_n       <= 1'b1;
      transfer_in_progress_n <= 1'b1;
      bcnt                   <= 2'd0;
      line_locked            <= 1'b0;
    end
    else if (ce)
    begin
      case (st)
        ST_IDLE:
        begin
          if (take)
          begin
            st                     <= ST_START;
            transfer_start_n       <= 1'b0;
            transfer_in_progress_n <= 1'b0;
            bcnt                   <= 2'd0;
            line_locked            <= 1'b0;
          end
        end
        ST_START:
        begin
          st               <= ST_WAIT;
          transfer_start_n <= 1'b1;
        end
        ST_WAIT, ST_BURST:
        begin
          if (sampling && more)
          begin
            if (is_line)
              bcnt <= 2'(bcnt + 1'b1);
            if (tbi_hit)
              line_locked <= 1'b1;
            if (st == ST_BURST || (first_line && !tbi_hit))
              st <= ST_BURST;
            else
            begin
              st               <= ST_START;
              transfer_start_n <= 1'b0;
            end
          end
          else if (sampling && take)
          begin
            st               <= ST_START;
            transfer_start_n <= 1'b0;
            bcnt             <= 2'd0;
            line_locked      <= 1'b0;
          end
          else if (sampling)
          begin
            st                     <= ST_IDLE;
            transfer_in_progress_n <= 1'b1;
            line_locked            <= 1'b0;
          end
        end
        default:
          st <= ST_IDLE;
      endcase
    end
  end

  // address, size and attributes
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cur               <= '0;
      rem               <= 3'h0;
      bus_addr          <= 32'h0;
      read_write_n      <= 1'b1;
      xfer_size         <= PBR_LONG;
      access_type       <= 2'h0;
      access_modifier   <= 3'h0;
      user_attr_bits    <= 2'h0;
      cache_inhibit_out <= 1'b0;
    end
    else if (ce)
    begin
      read_write_n <= 1'b1;
      if (take)
      begin
        cur             <= hold;
        bus_addr        <= hold.addr;
        access_type     <= hold.acc_type;
        access_modifier <= hold.acc_mod;
        user_attr_bits  <= hold.upa;
        if (hold.op_size == PBR_LINE)
        begin
          xfer_size         <= PBR_LINE;
          rem               <= 3'h0;
          cache_inhibit_out <= hold.block_move && hold.noncache;
        end
        else
        begin
          xfer_size         <= piece_size(hold.addr[1:0], size_bytes(hold.op_size));
          rem               <= 3'(size_bytes(hold.op_size)
                               - size_bytes(piece_size(hold.addr[1:0], size_bytes(hold.op_size))));
          cache_inhibit_out <= hold.noncache || hold.alt_space;
        end
      end
      else if (sampling && more && !is_line)
      begin
        bus_addr  <= nxt_addr;
        xfer_size <= piece_size(nxt_addr[1:0], rem);
        rem       <= 3'(rem - size_bytes(piece_size(nxt_addr[1:0], rem)));
      end
      else if (sampling && more && (tbi_hit || line_locked))
      begin
        bus_addr[3:2] <= 2'(bus_addr[3:2] + 1'b1);
        xfer_size     <= PBR_LONG;
      end
    end
  end

  // line cache inhibit latch
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      line_ci <= 1'b0;
    else if (ce && sampling && first_line)
      line_ci <= !cache_inhibit_in_n;
  end

  always_comb
  begin
    beat.data  = data_in;
    beat.lane  = bus_addr[1:0];
    beat.size  = xfer_size;
    beat.last  = !more;
    if (!is_line)
      beat.cache_inhibit = 1'b0;
    else if (first_line)
      beat.cache_inhibit = !cache_inhibit_in_n;
    else
      beat.cache_inhibit = line_ci;
  end

  pbr_fifo #(
    .W     ($bits(pbr_beat_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .in_valid  (sampling),
    .in_ready  (fifo_ready),
    .in_data   (beat),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_beat),
    .level     (fifo_level)
  );

  default clocking cb @(posedge sys_clk iff ce);
  endclocking
  default disable iff (sys_rst);

  sequence s_start;
    !transfer_start_n;
  endsequence

  sequence s_line_nowait;
    (st == ST_START && xfer_size == PBR_LINE) ##1 (sampling && !tbi_hit)
      ##1 sampling ##1 sampling ##1 sampling;
  endsequence

  sequence s_first_inhibit;
    sampling && tbi_hit;
  endsequence

  property p_ts_one;
    s_start |=> transfer_start_n && st == ST_WAIT;
  endproperty
  a_ts_one: assert property (p_ts_one) else $error("start held past clock 1");

  property p_tip_with_ts;
    s_start |-> !transfer_in_progress_n && read_write_n;
  endproperty
  a_tip_with_ts: assert property (p_tip_with_ts) else $error("start without in-progress");

  property p_align;
    s_start |-> (xfer_size != PBR_WORD || !bus_addr[0])
      && (xfer_size != PBR_LONG || line_locked || bus_addr[1:0] == 2'b00);
  endproperty
  a_align: assert property (p_align) else $error("misaligned bus cycle");

  property p_line_lows;
    s_start && line_locked |-> bus_addr[1:0] == cur.addr[1:0];
  endproperty
  a_line_lows: assert property (p_line_lows) else $error("line low bits changed");

  property p_burst_hold;
    st == ST_BURST |-> $stable(bus_addr) && $stable(xfer_size) && $stable(access_type);
  endproperty
  a_burst_hold: assert property (p_burst_hold) else $error("burst address moved");

  property p_tbi_inc;
    s_first_inhibit |=> s_start && xfer_size == PBR_LONG
      && bus_addr[3:2] == 2'($past(bus_addr[3:2]) + 2'd1);
  endproperty
  a_tbi_inc: assert property (p_tbi_inc) else $error("no long-word follow-up");

  property p_line_five;
    s_line_nowait |-> !more;
  endproperty
  a_line_five: assert property (p_line_five) else $error("burst line not five clocks");

  property p_ci_single;
    sampling && !is_line |-> !beat.cache_inhibit;
  endproperty
  a_ci_single: assert property (p_ci_single) else $error("cache inhibit on single read");

  property p_idle_quiet;
    st == ST_IDLE |-> transfer_start_n && transfer_in_progress_n;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle bus driven active");

  property p_no_ack_wait;
    st == ST_WAIT && !sampling |=> st == ST_WAIT && $stable(bus_addr);
  endproperty
  a_no_ack_wait: assert property (p_no_ack_wait) else $error("cycle ended without ack");
endmodule

// ==== sim/pbr_slave.sv ====
`timescale 1ns/1ps

module pbr_slave (
  // clock
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  // bus from the controller
  input  wire logic [31:0]        bus_addr,
  input  wire pbr_pkg::pbr_size_t xfer_size,
  input  wire logic               transfer_start_n,
  // behaviour
  input  wire logic [1:0]         waits,
  input  wire logic [1:0]         inh,
  input  wire logic               cinh,
  // answers
  output logic [31:0]             data_in,
  output logic                    xfer_acknowledge_n,
  output logic                    burst_inhibit_in_n,
  output logic                    cache_inhibit_in_n
);
  import pbr_pkg::*;
  logic [31:0] a;
  int          left;
  int          w;
  logic        first;
  logic        line;

  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      left = 0;
      data_in <= 32'h0;
      xfer_acknowledge_n <= 1'b1;
      burst_inhibit_in_n <= 1'b1;
      cache_inhibit_in_n <= 1'b1;
    end
    else
    begin
      if (!transfer_start_n)
      begin
        a = bus_addr;
        line = xfer_size == PBR_LINE;
        left = line ? 4 : 1;
        w = waits;
        first = 1'b1;
      end
      // released lines: pulled up, data bus keeps toggling
      xfer_acknowledge_n <= 1'b1;
      burst_inhibit_in_n <= 1'b1;
      cache_inhibit_in_n <= 1'b1;
      data_in <= ~data_in;
      if (left > 0 && w > 0)
        w = w - 1;
      else if (left > 0)
      begin
        xfer_acknowledge_n <= 1'b0;
        data_in <= ~{a[31:2], 2'b00};
        // later beats assert cache inhibit the other way round and take burst inhibit from inh[1]
        burst_inhibit_in_n <= ~(first ? inh[0] : inh[1]);
        cache_inhibit_in_n <= first ? ~cinh : cinh;
        left = (line && first && inh[0]) ? 0 : left - 1;
        a[3:2] = a[3:2] + 2'h1;
        first = 1'b0;
        w = waits;
      end
    end
  end
endmodule

// ==== sim/tb_pbr_read_ctrl.sv ====
`timescale 1ns/1ps

module tb_pbr_read_ctrl;
  import pbr_pkg::*;
  logic               sys_clk, sys_rst, ce, req_valid, req_ready, rd_valid, rd_ready;
  logic               line_locked, read_write_n, cache_inhibit_out;
  logic               transfer_start_n, transfer_in_progress_n;
  logic               xfer_acknowledge_n, burst_inhibit_in_n, cache_inhibit_in_n;
  logic [31:0]        bus_addr, data_in, st;
  logic [1:0]         access_type, user_attr_bits, waits, inh;
  logic [2:0]         access_modifier;
  logic               cinh, stall, fast;
  pbr_req_t           req, r;
  pbr_beat_t          rd_beat;
  pbr_size_t          xfer_size;
  logic [43:0]        eb[$];
  logic [43:0]        la;
  pbr_beat_t          bq[$];
  int                 mismatches, samples_checked, tcnt, tlast;

  pbr_read_ctrl #(.DEPTH(16)) i_dut (
    .sys_clk, .sys_rst, .ce, .req_valid, .req_ready, .req, .rd_valid, .rd_ready,
    .rd_beat, .line_locked, .bus_addr, .read_write_n, .xfer_size, .access_type,
    .access_modifier, .user_attr_bits, .cache_inhibit_out, .transfer_start_n,
    .transfer_in_progress_n, .data_in, .xfer_acknowledge_n, .burst_inhibit_in_n,
    .cache_inhibit_in_n
  );

  pbr_slave i_slave (
    .sys_clk, .sys_rst, .bus_addr, .xfer_size, .transfer_start_n, .waits, .inh,
    .cinh, .data_in, .xfer_acknowledge_n, .burst_inhibit_in_n, .cache_inhibit_in_n
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction

  function automatic pbr_req_t rreq();
    return pbr_req_t'(44'({xs(), xs()}));
  endfunction

  task automatic end_sim();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    samples_checked++;
    if (e !== s)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  // expected bus cycles and returned beats of one request
  function automatic void model(input pbr_req_t q);
    logic [31:0] a;
    pbr_size_t   s;
    int          n;
    int          k;
    logic        ci;
    a = q.addr;
    if (q.op_size == PBR_LINE)
    begin
      ci = q.block_move & q.noncache;
      for (int i = 0; i < 4; i++)
      begin
        s = (i > 0 && inh[0]) ? PBR_LONG : PBR_LINE;
        if (i == 0 || inh[0])
          eb.push_back({a, s, ci, q.upa, q.acc_type, q.acc_mod, 1'b1, i > 0});
        bq.push_back({~{a[31:2], 2'b00}, q.addr[1:0], s, cinh, i == 3});
        a[3:2] = a[3:2] + 2'h1;
      end
    end
    else
    begin
      ci = q.noncache | q.alt_space;
      n = q.op_size == PBR_BYTE ? 1 : q.op_size == PBR_WORD ? 2 : 4;
      while (n > 0)
      begin
        s = (a[0] || n == 1) ? PBR_BYTE : (a[1] || n < 4) ? PBR_WORD : PBR_LONG;
        k = s == PBR_BYTE ? 1 : s == PBR_WORD ? 2 : 4;
        eb.push_back({a, s, ci, q.upa, q.acc_type, q.acc_mod, 1'b1, 1'b0});
        bq.push_back({~{a[31:2], 2'b00}, a[1:0], s, 1'b0, n == k});
        a = a + k;
        n = n - k;
      end
    end
  endfunction

  task automatic send(input pbr_req_t q, input bit keep);
    int n;
    model(q);
    req <= q;
    req_valid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 400);
    if (n >= 400)
      mismatches++;
    if (!keep)
      req_valid <= 1'b0;
  endtask

  task automatic drain();
    int n;
    n = 0;
    while ((bq.size() || eb.size() || transfer_in_progress_n !== 1'b1) && n < 3000)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000)
    begin
      mismatches++;
      end_sim();
    end
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic mode(input logic [1:0] i, input logic c, input logic f);
    inh <= i;
    cinh <= c;
    fast <= f;
    @(posedge sys_clk);
  endtask

  always @(posedge sys_clk)
  begin
    rd_ready <= !stall && xs() % 4 != 0;
    waits <= fast ? 2'h0 : 2'(xs() % 3);
  end

  always @(posedge sys_clk)
  begin
    if (!sys_rst && transfer_start_n === 1'b0)
    begin
      la = {bus_addr, xfer_size, cache_inhibit_out, user_attr_bits, access_type,
            access_modifier, read_write_n, line_locked};
      chk("bus_cycle", eb.size() ? eb.pop_front() : '1, la);
    end
    else if (!sys_rst && transfer_in_progress_n === 1'b0)
      chk("bus_hold", la[43:2], {bus_addr, xfer_size, cache_inhibit_out, user_attr_bits,
          access_type, access_modifier});
    if (!sys_rst && rd_valid === 1'b1 && rd_ready === 1'b1)
      chk("beat", bq.size() ? bq.pop_front() : '1, rd_beat);
    if (transfer_in_progress_n === 1'b0)
      tcnt++;
    else if (tcnt > 0)
    begin
      tlast = tcnt;
      tcnt = 0;
    end
  end

  initial
  begin
    #(25ns * 40000);
    mismatches++;
    end_sim();
  end

  initial
  begin
    sys_rst = 1'b1;
    ce = 1'b1;
    req_valid = 1'b0;
    req = '0;
    rd_ready = 1'b0;
    waits = 2'h0;
    {inh, cinh, stall, fast} = 5'h01;
    {mismatches, samples_checked, tcnt, tlast} = '0;
    st = 32'd68013;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3)
    begin
      @(posedge sys_clk);
      chk("idle", 2'h3, {transfer_start_n, transfer_in_progress_n});
    end
    for (int i = 0; i < 2; i++)
    begin
      mode(2'(i), 1'b0, 1'b1);
      r = rreq();
      r.op_size = PBR_LINE;
      send(r, 1'b0);
      drain();
      chk("tip_len", i ? 8 : 5, tlast);
    end
    // long, byte and word at every alignment, back to back, inhibit asserted
    mode(2'h0, 1'b1, 1'b0);
    for (int i = 0; i < 12; i++)
    begin
      r = rreq();
      r.op_size = pbr_size_t'(i / 4);
      r.addr[1:0] = 2'(i);
      send(r, i < 11);
    end
    drain();
    for (int i = 0; i < 8; i++)
    begin
      mode(2'(i), i[2], 1'b0);
      for (int j = 0; j < 3; j++)
      begin
        r = rreq();
        r.op_size = PBR_LINE;
        send(r, j < 2);
      end
      drain();
    end
    for (int b = 0; b < 4; b++)
    begin
      mode(2'(xs()), 1'(xs()), 1'b0);
      for (int j = 0; j < 10; j++)
        send(rreq(), j < 9);
      drain();
    end
    // fill the buffer with the reader stalled
    mode(2'h1, 1'b0, 1'b0);
    stall <= 1'b1;
    r.op_size = PBR_LINE;
    for (int j = 0; j < 5; j++)
      send(r, j < 4);
    repeat (60) @(posedge sys_clk);
    chk("full", 3'h5, {rd_valid, req_ready, transfer_in_progress_n});
    stall <= 1'b0;
    drain();
    end_sim();
  end
endmodule
